// ---- common/watchdog_consts.vh ----
/*
 Constants for the watchdog reset timer: register offsets, field positions,
 reset values and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// Word offsets on the Wishbone bus (byte addresses)
`define WDG_OFS_COUNTER 4'h0
`define WDG_OFS_CONTROL 4'h4
`define WDG_OFS_STATUS 4'h8

// Field positions in the guard counter register
`define WDG_BIT_ACTIVE 0
`define WDG_BIT_SOFT_RESET 1
`define WDG_COUNTER_RESET 8'hFE

// Control register fields
`define WDG_CTL_HW_OPTION 0
`define WDG_CTL_EXT_STOP 1
`define WDG_CTL_STOP_REQ 2
`define WDG_CTL_EXIT_STOP 3

// Status register fields
`define WDG_STA_STOPPED 0
`define WDG_STA_WAITING 1
`define WDG_STA_RESET 2

// Timing
`define WDG_PERIOD_CYCLES 3072
`define WDG_CLK_MHZ 200
`define WDG_RESET_PULSE_NS 500
`define WDG_RESET_PULSE_CYCLES ((`WDG_RESET_PULSE_NS * `WDG_CLK_MHZ) / 1000)

`endif

// ---- testbench/watchdog_reset_timer_properties.sv ----
/*
 Port-level assertions for the watchdog reset timer.
 Assumes one clock, clk_sys, and reset_n low active.
*/
`timescale 1ns/10ps
module watchdog_reset_timer_properties #(
    parameter PERIOD = 8,
    parameter PULSE = 4
) (
    input wire clk_sys,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire nmi_level,
    input wire mcu_reset_n_ff,
    input wire stop_mode_ff,
    input wire wait_mode_ff
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Length of the current low phase of the reset request
    reg [15:0] low_cnt;
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt <= 16'h0000;
        else if (mcu_reset_n_ff)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    end
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_s;
        req_s ##0 !wb_we_i;
    endsequence
    a_ack_timely: assert property (req_s |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper data set");
    a_unmapped_zero: assert property (rd_s ##0 wb_adr_i == 4'hC |=> wb_dat_o == 32'h0)
        else $error("unmapped read");
    a_ctrl_bits: assert property (rd_s ##0 wb_adr_i == 4'h4 |=> wb_dat_o[7:2] == 6'h0)
        else $error("control readback");
    a_pulse_width: assert property ($rose(mcu_reset_n_ff) |-> low_cnt == PULSE)
        else $error("reset pulse width");
    a_pulse_max: assert property (low_cnt <= PULSE)
        else $error("reset pulse too long");
    a_mode_excl: assert property (!(stop_mode_ff && wait_mode_ff))
        else $error("stop and wait");
endmodule // watchdog_reset_timer_properties
bind watchdog_reset_timer watchdog_reset_timer_properties #(.PERIOD(PERIOD), .PULSE(PULSE)) u_props (.*);

// ---- testbench/watchdog_reset_timer_tb.sv ----
/*
 Bench for the watchdog reset timer.
 Assumes PERIOD 8 and PULSE 4 to keep runs short.
*/
`timescale 1ns/10ps
module watchdog_reset_timer_tb;
    reg clk_sys = 0;
    reg reset_n = 0;
    reg cyc = 0;
    reg we = 0;
    reg nmi = 0;
    reg [3:0] adr = 4'h0;
    reg [31:0] dat = 32'h0;
    wire [31:0] dato;
    wire ack;
    wire rst_o;
    wire stop_o;
    wire wait_o;
    integer fails = 0;
    integer total_checks = 0;
    integer n;
    reg [31:0] r;
    reg [31:0] q;
    always #2.5 clk_sys = ~clk_sys;
    watchdog_reset_timer #(.PERIOD(8), .PULSE(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .nmi_level(nmi),
        .mcu_reset_n_ff(rst_o), .stop_mode_ff(stop_o), .wait_mode_ff(wait_o));
    task close_out;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task hang(input integer k);
        if (k >= 200)
        begin
            fails = fails + 1;
            close_out;
        end
    endtask
    task wb(input w, input [3:0] a, input [7:0] d);
        integer k;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        k = 0;
        @(posedge clk_sys);
        while (ack !== 1'b1 && k < 200)
        begin
            @(posedge clk_sys);
            k = k + 1;
        end
        hang(k);
        r = dato;
        cyc <= 1'b0;
    endtask
    // Counts edges until the reset request shows level v
    task wrst(input v);
        n = 0;
        while (rst_o !== v && n < 200)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        hang(n);
    endtask
    task t_reset;
        wb(0, 4'h0, 8'h00);
        chk("counter", 32'hFE, r);
        wb(0, 4'hC, 8'h00);
        chk("unmapped", 32'h0, r);
        $display("test reset done");
    endtask
    task t_timer;
        wb(1, 4'h0, 8'h02);
        repeat (18) @(posedge clk_sys);
        wb(0, 4'h0, 8'h00);
        chk("timer", 32'h7C, r);
        q = r;
        wb(0, 4'h0, 8'h00);
        chk("timer twice", q, r);
        chk("no reset", 1, rst_o);
        $display("test timer done");
    endtask
    task t_expire;
        wb(1, 4'h0, 8'h03);
        wrst(0);
        chk("delay", 1, n >= 6 && n <= 12);
        wrst(1);
        chk("width", 4, n);
        wb(0, 4'h0, 8'h00);
        chk("after", 32'hFE, r);
        $display("test expire done");
    endtask
    task t_soft;
        wb(1, 4'h0, 8'hFF);
        wb(1, 4'h0, 8'hFE);
        wb(0, 4'h0, 8'h00);
        chk("active", 1, r[0]);
        wb(1, 4'h0, 8'hFD);
        wrst(0);
        chk("soft", 1, n <= 3);
        wrst(1);
        $display("test soft done");
    endtask
    task t_hw;
        wb(1, 4'h4, 8'h01);
        wb(1, 4'h0, 8'hFE);
        wb(0, 4'h0, 8'h00);
        chk("hw active", 1, r[0]);
        wb(1, 4'h0, 8'hFC);
        wrst(0);
        chk("hw soft", 1, n <= 3);
        wrst(1);
        wb(0, 4'h4, 8'h00);
        chk("hw kept", 32'h1, r);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        wb(0, 4'h4, 8'h00);
        chk("hw cleared", 32'h0, r);
        $display("test hw done");
    endtask
    task t_stop;
        wb(1, 4'h4, 8'h04);
        repeat (2) @(posedge clk_sys);
        chk("stop idle", 1, stop_o);
        wb(1, 4'h4, 8'h08);
        wb(1, 4'h0, 8'hFF);
        wb(1, 4'h4, 8'h04);
        repeat (2) @(posedge clk_sys);
        chk("wait", 2'b01, {stop_o, wait_o});
        wb(1, 4'h4, 8'h0A);
        wb(1, 4'h4, 8'h06);
        repeat (2) @(posedge clk_sys);
        chk("nmi low", 2'b01, {stop_o, wait_o});
        wb(1, 4'h4, 8'h0A);
        nmi <= 1'b1;
        wb(1, 4'h4, 8'h06);
        wb(0, 4'h0, 8'h00);
        q = r;
        repeat (20) @(posedge clk_sys);
        wb(0, 4'h0, 8'h00);
        chk("frozen", q, r);
        wb(1, 4'h4, 8'h0A);
        repeat (20) @(posedge clk_sys);
        wb(0, 4'h0, 8'h00);
        chk("resumed", 1, r !== q);
        $display("test stop done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset;
        t_timer;
        t_expire;
        t_soft;
        t_hw;
        t_stop;
        close_out;
    end
endmodule // watchdog_reset_timer_tb

// ---- verilog/watchdog_prescaler.v ----
/*
 Divider producing one-cycle tick every PERIOD system clocks.
 Assumes a synchronous restart request from the parent.
*/
`timescale 1ns/10ps
module watchdog_prescaler #(
    parameter PERIOD = 3072
) (
    input wire clk_sys,
    input wire reset_n,
    input wire restart,
    input wire run,
    output reg tick_ff
);
    reg [11:0] count_ff;
    wire last = (count_ff == PERIOD[11:0] - 12'h001);

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= 12'h000;
            tick_ff <= 1'b0;
        end
        else if (restart)
        begin
            count_ff <= 12'h000;
            tick_ff <= 1'b0;
        end
        else if (run)
        begin
            count_ff <= last ? 12'h000 : count_ff + 12'h001;
            tick_ff <= last;
        end
        else
        begin
            tick_ff <= 1'b0;
        end
    end
endmodule // watchdog_prescaler

// ---- verilog/watchdog_reset_timer.v ----
/*
 Watchdog reset timer with a classic Wishbone slave for its registers.
 Assumes a single 200 MHz clock and synchronous pin inputs.
*/
// Design decisions made here: the Wishbone register port and the address map.
// What this block does
// RULE_01: Count down once every 3072 clocks
// RULE_02: Timeout programmable in 64 steps
// RULE_03: Hardware option: always active, writes ignored
// RULE_04: Hardware option: active bit read unreliable
// RULE_05: Software option: inactive until software sets
// RULE_06: Once active, cannot clear until reset
// RULE_07: Active and soft-reset bit zero: reset
// RULE_08: Software reloads register before expiry
// RULE_09: Software reloads only FEh down 02h
// RULE_10: Delay bits count decrements before reset
// RULE_11: Clearing soft-reset bit while active resets
// RULE_12: Inactive counter is 7-bit reversed timer
// RULE_13: Software reads timer twice to validate
// RULE_14: 8 MHz oscillator gives 384 us step
// RULE_15: Keep counting during WAIT mode
// RULE_16: Inactive watchdog: STOP enters STOP
// RULE_17: Active, no external control: STOP as WAIT
// RULE_18: External control, NMI low: STOP as WAIT
// RULE_19: External control, NMI high: freeze, STOP
// RULE_20: Leaving STOP resumes counting from frozen
// RULE_21: Delay bits reversed in 7:2, LSB bit7
// RULE_22: Register resets to 1111 1110
// RULE_23: Inactive: soft-reset bit is timer MSB
// RULE_24: Write loads counter, restarts period
// RULE_25: Reset request held fixed cycle count
`timescale 1ns/10ps
`include "watchdog_consts.vh"
module watchdog_reset_timer #(
    parameter PERIOD = `WDG_PERIOD_CYCLES, // see RULE_14
    parameter PULSE = `WDG_RESET_PULSE_CYCLES
) (
    input wire clk_sys,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire nmi_level,
    output reg mcu_reset_n_ff,
    output reg stop_mode_ff,
    output reg wait_mode_ff
);
    localparam ST_RUN = 3'b001;
    localparam ST_STOP = 3'b010;
    localparam ST_RST = 3'b100;

    // Physical counter: bit 6 is the soft-reset bit, bits 5:0 the delay
    reg [6:0] counter_ff;
    reg active_ff;
    reg hw_option_ff;
    reg ext_stop_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [15:0] pulse_ff;
    reg [6:0] nxt_counter;
    reg nxt_active;

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire wr_cnt = wr && (wb_adr_i == `WDG_OFS_COUNTER);
    wire wr_ctl = wr && (wb_adr_i == `WDG_OFS_CONTROL);
    wire tick;
    wire restart = wr_cnt;
    wire is_active = active_ff || hw_option_ff;

    // Reverse delay bits into register order
    function [7:0] to_reg;
        input [6:0] cnt;
        input act;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                to_reg[7 - i] = cnt[i];
            to_reg[1] = cnt[6];
            to_reg[0] = act;
        end
    endfunction

    function [6:0] from_reg;
        input [7:0] r;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                from_reg[i] = r[7 - i];
            from_reg[6] = r[1];
        end
    endfunction

    // Decrement stalls in STOP and while the reset pulse is out
    watchdog_prescaler #(
        .PERIOD(PERIOD)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(restart),
        .run(state_ff == ST_RUN), // see RULE_15 see RULE_20
        .tick_ff(tick)
    );

    always @*
    begin
        nxt_counter = counter_ff;
        nxt_active = active_ff;
        if (wr_cnt)
        begin
            nxt_counter = from_reg(wb_dat_i[7:0]); // see RULE_24 see RULE_21
            if (wb_dat_i[`WDG_BIT_ACTIVE])
                nxt_active = 1'b1; // see RULE_05 see RULE_06
        end
        else if (tick)
        begin
            nxt_counter = counter_ff - 7'h01; // see RULE_01 see RULE_02 see RULE_10 see RULE_12
        end
    end

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:
            begin
                // Soft-reset bit low while active, by decrement or by write
                if (is_active && !nxt_counter[6])
                    nxt_state = ST_RST; // see RULE_07 see RULE_11 see RULE_23
                else if (wr_ctl && wb_dat_i[`WDG_CTL_STOP_REQ])
                begin
                    if (!is_active)
                        nxt_state = ST_STOP; // see RULE_16
                    else if (ext_stop_ff && nmi_level)
                        nxt_state = ST_STOP; // see RULE_19
                end
            end
            ST_STOP:
            begin
                if (wr_ctl && wb_dat_i[`WDG_CTL_EXIT_STOP])
                    nxt_state = ST_RUN; // see RULE_20
            end
            ST_RST:
            begin
                if (pulse_ff == 16'h0001)
                    nxt_state = ST_RUN; // see RULE_25
            end
            default:
                nxt_state = ST_RUN;
        endcase
    end

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            counter_ff <= 7'h7F; // see RULE_22
            active_ff <= 1'b0;
            hw_option_ff <= 1'b0;
            ext_stop_ff <= 1'b0;
            state_ff <= ST_RUN;
            pulse_ff <= 16'h0000;
            mcu_reset_n_ff <= 1'b1;
            stop_mode_ff <= 1'b0;
            wait_mode_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state == ST_RST && state_ff != ST_RST)
            begin
                // The pulse reloads the counter and clears the active bit; the option bits keep their values
                pulse_ff <= PULSE[15:0];
                counter_ff <= 7'h7F;
                active_ff <= 1'b0;
                mcu_reset_n_ff <= 1'b0; // see RULE_07 see RULE_25
            end
            else if (state_ff == ST_RST)
            begin
                pulse_ff <= pulse_ff - 16'h0001;
                mcu_reset_n_ff <= (pulse_ff == 16'h0001);
            end
            else
            begin
                counter_ff <= nxt_counter;
                active_ff <= nxt_active;
            end
            if (wr_ctl)
            begin
                // The hardware option bit is taken only while the watchdog is still inactive; ext stop always
                if (!is_active)
                    hw_option_ff <= wb_dat_i[`WDG_CTL_HW_OPTION]; // see RULE_03
                ext_stop_ff <= wb_dat_i[`WDG_CTL_EXT_STOP];
            end
            stop_mode_ff <= (nxt_state == ST_STOP);
            if (wr_ctl && wb_dat_i[`WDG_CTL_STOP_REQ] && nxt_state == ST_RUN && is_active)
                wait_mode_ff <= 1'b1; // see RULE_17 see RULE_18
            else if (wr_ctl && wb_dat_i[`WDG_CTL_EXIT_STOP])
                wait_mode_ff <= 1'b0;
        end
    end

    // Wishbone slave: one wait state, ack for one cycle
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `WDG_OFS_COUNTER:
                        wb_dat_o[7:0] <= to_reg(counter_ff, is_active); // see RULE_04 see RULE_21
                    `WDG_OFS_CONTROL:
                        wb_dat_o[1:0] <= {ext_stop_ff, hw_option_ff};
                    `WDG_OFS_STATUS:
                        wb_dat_o[2:0] <= {state_ff == ST_RST, wait_mode_ff, stop_mode_ff};
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // watchdog_reset_timer
